// ===== design/ulsi_top.sv
// Functional notes
// R1: Line status decoded at select 5, any latch
// R2: Reset: both empty bits one, others zero
// R3: FIFO error flag tracks tagged queued characters
// R4: Transmitter empty only when both stages empty
// R5: Holding empty clears on load, sets on transfer
// R6: FIFO mode holding empty follows FIFO emptiness
// R7: FIFO enable change gives immediate transmit interrupt
// R8: Lone-character FIFO empty delayed one character
// R9: Break when input low beyond frame time
// R10: After break, wait half bit high
// R11: Framing error on zero stop bit
// R12: Parity error per even parity select
// R13: FIFO mode tags shown at FIFO head
// R14: Status read clears four error flags
// R15: Character mode overrun on unread buffer
// R16: FIFO full overrun flagged, character dropped
// R17: Data ready set on entry, cleared properly
// R18: Error bits raise line status interrupt
// R19: Writes change all status bits but seven and, in FIFO mode, zero
// R20: Four interrupt levels in fixed priority
// R21: Id access freezes highest pending interrupt
// R22: Id register read-only at select 2
// R23: Id bits seven, six mirror FIFO mode
// R24: Id bit zero low while interrupt pending
// R25: Id bits three..one encode source
// R26: New error wins over same-cycle clear
`timescale 1ns/1ps
`default_nettype none
module ulsi_top (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire ulsi_pkg::ulsi_bus_type bus_i,
	output logic [7:0] rdata_o,
	input wire ulsi_pkg::ulsi_ctrl_type ctrl_i,
	input wire logic serial_input_pin_i,
	input wire logic rx_done_i,
	input wire ulsi_pkg::ulsi_rx_char_type rx_char_i,
	input wire logic rx_buf_read_i,
	output logic rx_in_ready_o,
	output ulsi_pkg::ulsi_rx_char_type rx_head_o,
	input wire logic tx_write_i,
	input wire logic tx_fifo_empty_i,
	input wire logic tx_fifo_two_i,
	input wire logic tx_load_shift_i,
	input wire logic tx_shift_busy_i,
	input wire logic modem_pending_i,
	output logic rx_hold_o,
	output logic irq_o
);
	import ulsi_pkg::*;

	// Receiver gating states
	typedef enum logic [2:0] {
		ULSI_RUN = 3'b001,
		ULSI_BRK = 3'b010,
		ULSI_MARK = 3'b100
	} ulsi_rx_state_type;

	// Whole module state
	typedef struct packed {
		logic [7:0] ls;
		logic [7:0] rdata;
		ulsi_rx_state_type rxst;
		logic [ULSI_CNT_W-1:0] low_cnt;
		logic [ULSI_CNT_W-1:0] high_cnt;
		logic [ULSI_CNT_W-1:0] thr_cnt;
		logic thr_wait;
		logic had_two;
		logic thr_irq;
		logic fifo_mode_q;
		logic id_busy;
		logic [3:0] id_frozen;
		logic [ULSI_OCC_W-1:0] tag_cnt;
		logic [ULSI_OCC_W-1:0] occ; // Receive FIFO occupancy
		logic head_seen; // Head tags already shown once
	} ulsi_state_type;

	ulsi_state_type s_r;
	ulsi_state_type s_nxt;

	// Receive FIFO handshake wires
	logic fifo_in_valid;
	logic fifo_out_valid;
	logic fifo_pop;
	ulsi_rx_char_type fifo_head;
	ulsi_rx_char_type rx_tagged;

	// Priority encode of enabled pending sources
	function automatic logic [3:0] ulsi_encode(input logic line,
		input logic rxd, input logic thr, input logic mdm);
		logic [3:0] r;
		r = 4'h1;
		if (line) r = {ULSI_SRC_LINE, 1'b0}; // [R20]
		else if (rxd) r = {ULSI_SRC_RXDATA, 1'b0};
		else if (thr) r = {ULSI_SRC_THR, 1'b0};
		else if (mdm) r = {ULSI_SRC_MODEM, 1'b0};
		return r;
	endfunction : ulsi_encode

	// Parity check: even select expects even count of ones
	function automatic logic ulsi_par_bad(input logic [7:0] d,
		input logic even);
		return even ? ^d : ~^d;
	endfunction : ulsi_par_bad

	logic rd_ls;
	logic wr_ls;
	logic rd_id;
	logic fifo_on;
	logic line_pend;
	logic rxd_pend;
	logic thr_pend;
	logic mdm_pend;
	logic [3:0] live_id;

	// Register decode ignores the divisor latch select
	assign rd_ls = ce_i && bus_i.cs && bus_i.rd &&
		bus_i.addr == ULSI_ADDR_LINE_STATUS; // [R1]
	assign wr_ls = ce_i && bus_i.cs && bus_i.wr &&
		bus_i.addr == ULSI_ADDR_LINE_STATUS; // [R19]
	assign rd_id = bus_i.cs && bus_i.addr == ULSI_ADDR_INT_ID; // [R22]
	assign fifo_on = ctrl_i.fifo_mode;

	// Tag the incoming character with parity, framing and break
	always_comb begin
		rx_tagged = rx_char_i;
		// The par field becomes the parity error flag, not the received bit
		rx_tagged.par = rx_char_i.par ^
			ulsi_par_bad(rx_char_i.data, ctrl_i.even_parity); // [R12]
		rx_tagged.brk = rx_char_i.brk |
			(s_r.low_cnt >= ULSI_CNT_W'(ULSI_FRAME_CYC)); // [R9]
	end

	// Characters enter the FIFO only while there is room
	assign fifo_in_valid = fifo_on && rx_done_i &&
		s_r.rxst == ULSI_RUN;
	assign fifo_pop = fifo_on && rx_buf_read_i && fifo_out_valid;

	ulsi_fifo #(
		.WIDTH($bits(ulsi_rx_char_type)),
		.DEPTH(ULSI_FIFO_DEPTH)
	) u_rx_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.clear_i(fifo_on != s_r.fifo_mode_q),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(rx_in_ready_o),
		.in_data_i(rx_tagged),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(rx_buf_read_i),
		.out_data_o(fifo_head)
	);
	assign rx_head_o = fifo_head;

	// Interrupt pending terms, each gated by its enable
	assign line_pend = ctrl_i.en_line && |s_r.ls[4:1]; // [R18]
	assign rxd_pend = ctrl_i.en_rxdata && s_r.ls[ULSI_LS_RX_READY];
	assign thr_pend = ctrl_i.en_thr && s_r.thr_irq; // [R5]
	assign mdm_pend = ctrl_i.en_modem && modem_pending_i;
	assign live_id = ulsi_encode(line_pend, rxd_pend, thr_pend,
		mdm_pend);

	// Next-state logic for status, receiver gate and id freeze
	always_comb begin
		logic head_tags;
		logic ovr_evt;
		logic char_in;
		logic brk_evt;
		brk_evt = 1'b0;
		head_tags = 1'b0;
		ovr_evt = 1'b0;
		char_in = 1'b0;
		s_nxt = s_r;
		s_nxt.fifo_mode_q = fifo_on;
		s_nxt.rdata = 8'h00;

		// Break detect and half-bit high recovery
		case (s_r.rxst)
			ULSI_RUN: begin
				s_nxt.low_cnt = serial_input_pin_i ? '0 :
					s_r.low_cnt + 1'b1;
				if (s_r.low_cnt >= ULSI_CNT_W'(ULSI_FRAME_CYC)) begin
					s_nxt.rxst = ULSI_BRK; // [R9]
					brk_evt = 1'b1;
				end
			end
			ULSI_BRK: begin
				s_nxt.low_cnt = '0;
				s_nxt.high_cnt = '0;
				if (serial_input_pin_i) s_nxt.rxst = ULSI_MARK;
			end
			ULSI_MARK: begin
				s_nxt.high_cnt = s_r.high_cnt + 1'b1;
				if (!serial_input_pin_i) begin
					s_nxt.rxst = ULSI_BRK;
				end else if (s_r.high_cnt >=
					ULSI_CNT_W'(ULSI_HALF_BIT_CYC - 1)) begin
					s_nxt.rxst = ULSI_RUN; // [R10]
				end
			end
			default: s_nxt.rxst = ULSI_RUN;
		endcase

		// Clearing read goes first so that events below win
		if (rd_ls) begin
			s_nxt.rdata = s_r.ls;
			s_nxt.ls[4:1] = 4'h0; // [R14]
			if (s_r.tag_cnt == '0 ||
				(s_r.tag_cnt == ULSI_OCC_W'(1) && fifo_pop &&
				(fifo_head.par | fifo_head.frm | fifo_head.brk))) begin
				s_nxt.ls[ULSI_LS_FIFO_ERR] = 1'b0; // [R3]
			end
		end else if (rd_id) begin
			s_nxt.rdata = {{2{fifo_on}}, 2'b00, s_r.id_busy ?
				s_r.id_frozen : live_id}; // [R23]
		end

		// Host write sets or clears any bit but the FIFO error flag and, in FIFO mode, data ready
		if (wr_ls) begin
			s_nxt.ls[6:0] = bus_i.wdata[6:0]; // [R19]
		end

		// Receive events
		if (s_r.rxst == ULSI_RUN && rx_done_i) begin
			if (fifo_on) begin
				ovr_evt = !rx_in_ready_o; // [R16]
				char_in = rx_in_ready_o;
			end else begin
				ovr_evt = s_r.ls[ULSI_LS_RX_READY] && !rx_buf_read_i;
				char_in = 1'b1; // [R15]
				s_nxt.ls[ULSI_LS_PARITY] = s_r.ls[ULSI_LS_PARITY] |
					rx_tagged.par; // [R26]
				s_nxt.ls[ULSI_LS_FRAMING] = s_r.ls[ULSI_LS_FRAMING] |
					rx_tagged.frm; // [R11]
				s_nxt.ls[ULSI_LS_BREAK] = s_r.ls[ULSI_LS_BREAK] |
					rx_tagged.brk;
			end
		end
		if (ovr_evt) s_nxt.ls[ULSI_LS_OVERRUN] = 1'b1; // [R26]
		// In character mode a line held low a whole frame flags break even with no character
		if (brk_evt && !fifo_on) s_nxt.ls[ULSI_LS_BREAK] = 1'b1; // [R9]

		// Count tagged characters queued in the FIFO
		if (char_in && fifo_on && (rx_tagged.par | rx_tagged.frm |
			rx_tagged.brk)) begin
			s_nxt.tag_cnt = s_nxt.tag_cnt + 1'b1;
			s_nxt.ls[ULSI_LS_FIFO_ERR] = 1'b1; // [R3]
		end
		if (fifo_pop && (fifo_head.par | fifo_head.frm | fifo_head.brk))
			s_nxt.tag_cnt = s_nxt.tag_cnt - 1'b1;
		if (!fifo_on) begin
			s_nxt.tag_cnt = '0;
			s_nxt.occ = '0;
			s_nxt.head_seen = 1'b0;
			s_nxt.ls[ULSI_LS_FIFO_ERR] = 1'b0; // [R3]
		end

		// Head tags become visible as the head character changes
		// Shown once per head so a status read really clears them
		if (fifo_on && fifo_out_valid && !s_r.head_seen) begin
			head_tags = 1'b1;
			s_nxt.head_seen = 1'b1;
			s_nxt.ls[ULSI_LS_PARITY] = s_nxt.ls[ULSI_LS_PARITY] |
				fifo_head.par; // [R13]
			s_nxt.ls[ULSI_LS_FRAMING] = s_nxt.ls[ULSI_LS_FRAMING] |
				fifo_head.frm;
			s_nxt.ls[ULSI_LS_BREAK] = s_nxt.ls[ULSI_LS_BREAK] |
				fifo_head.brk;
		end
		// A pop brings a new head whose tags are still to be shown
		if (fifo_pop) s_nxt.head_seen = 1'b0;

		// Data ready follows the tracked occupancy in FIFO mode
		if (fifo_on) begin
			s_nxt.occ = s_r.occ + ULSI_OCC_W'(char_in) -
				ULSI_OCC_W'(fifo_pop);
			if (fifo_on != s_r.fifo_mode_q) s_nxt.occ = '0;
			s_nxt.ls[ULSI_LS_RX_READY] = s_nxt.occ != '0; // [R17]
		end else if (char_in) begin
			s_nxt.ls[ULSI_LS_RX_READY] = 1'b1; // [R17]
		end else if (rx_buf_read_i) begin
			s_nxt.ls[ULSI_LS_RX_READY] = 1'b0;
		end

		// Transmit holding empty and one-character delay
		if (!fifo_on) begin
			s_nxt.thr_wait = 1'b0;
			s_nxt.had_two = 1'b0;
			if (tx_write_i) s_nxt.ls[ULSI_LS_THR_EMPTY] = 1'b0; // [R5]
			else if (tx_load_shift_i)
				s_nxt.ls[ULSI_LS_THR_EMPTY] = 1'b1;
		end else begin
			if (tx_fifo_two_i) s_nxt.had_two = 1'b1;
			if (tx_write_i) begin
				s_nxt.ls[ULSI_LS_THR_EMPTY] = 1'b0; // [R6]
				s_nxt.thr_wait = 1'b0;
			end else if (tx_fifo_empty_i &&
				!s_r.ls[ULSI_LS_THR_EMPTY] && !s_r.thr_wait) begin
				if (s_r.had_two) begin
					s_nxt.ls[ULSI_LS_THR_EMPTY] = 1'b1; // [R6]
				end else begin
					s_nxt.thr_wait = 1'b1; // [R8]
					s_nxt.thr_cnt = ULSI_CNT_W'(ULSI_THR_DELAY_CYC);
				end
				s_nxt.had_two = 1'b0;
			end else if (s_r.thr_wait) begin
				s_nxt.thr_cnt = s_r.thr_cnt - 1'b1;
				if (s_r.thr_cnt == ULSI_CNT_W'(1)) begin
					s_nxt.thr_wait = 1'b0;
					s_nxt.ls[ULSI_LS_THR_EMPTY] = 1'b1; // [R8]
				end
			end
		end
		s_nxt.ls[ULSI_LS_TX_EMPTY] = s_nxt.ls[ULSI_LS_THR_EMPTY] &&
			!tx_shift_busy_i && !tx_write_i; // [R4]
		if (wr_ls) s_nxt.ls[ULSI_LS_TX_EMPTY] = bus_i.wdata[6];

		// Transmit interrupt latch: rising empty, mode change
		if (s_nxt.ls[ULSI_LS_THR_EMPTY] && !s_r.ls[ULSI_LS_THR_EMPTY])
			s_nxt.thr_irq = 1'b1;
		if (fifo_on != s_r.fifo_mode_q &&
			s_r.ls[ULSI_LS_THR_EMPTY]) s_nxt.thr_irq = 1'b1; // [R7]
		if (tx_write_i) s_nxt.thr_irq = 1'b0;
		else if (rd_id && !s_r.id_busy &&
			live_id[3:1] == ULSI_SRC_THR && !live_id[0])
			s_nxt.thr_irq = 1'b0;

		// Freeze the id while it is addressed
		s_nxt.id_busy = rd_id;
		if (rd_id && !s_r.id_busy) begin
			s_nxt.id_frozen = live_id; // [R21]
		end
	end

	// Single state register, frozen while clock enable is low
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
			s_r.ls <= ULSI_LS_RESET; // [R2]
			s_r.rxst <= ULSI_RUN;
			// Holding register starts empty, so its interrupt is due
			s_r.thr_irq <= 1'b1; // [R5]
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign rdata_o = s_r.rdata;
	assign rx_hold_o = s_r.rxst != ULSI_RUN; // [R10]
	// Any enabled pending source; id bit zero is its inverse
	assign irq_o = !live_id[0]; // [R24]

	AST_RESET_LS: assert property (@(posedge ref_clk_i)
		$rose(rst_n_i) |-> s_r.ls == ULSI_LS_RESET) // [R2]
		else $error("line status reset value wrong");
	AST_READ_CLEARS: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) rd_ls && !fifo_on && !rx_done_i &&
		!wr_ls |=> s_r.ls[1] == 1'b0) // [R14]
		else $error("overrun not cleared by status read");
	AST_OVR_WINS: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) ce_i && rd_ls && s_r.rxst == ULSI_RUN &&
		rx_done_i && fifo_on && !rx_in_ready_o |=> s_r.ls[1]) // [R26]
		else $error("overrun lost to same cycle read");
	AST_FIFO_ERR_CHAR: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) !s_r.fifo_mode_q |-> !s_r.ls[7]) // [R3]
		else $error("fifo error flag set in character mode");
	AST_TX_EMPTY_ALL: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) s_r.ls[6] && !$past(wr_ls)
		|-> s_r.ls[5]) // [R4]
		else $error("tx empty without holding empty");
	AST_ID_MODE: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) ce_i && rd_id && !rd_ls
		|=> s_r.rdata[7:6] == {2{$past(fifo_on)}}) // [R23]
		else $error("id mode bits wrong");
	AST_LINE_PRIO: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) line_pend
		|-> live_id == {ULSI_SRC_LINE, 1'b0}) // [R25]
		else $error("line status not top priority");
	AST_BREAK_HOLD: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) ce_i && s_r.rxst == ULSI_BRK &&
		serial_input_pin_i |=> rx_hold_o) // [R10]
		else $error("receiver restarted without half bit high");
endmodule : ulsi_top
`default_nettype wire

// ===== design/ulsi_pkg.sv
package ulsi_pkg;
	// Register select values on the three address lines
	localparam logic [2:0] ULSI_ADDR_LINE_STATUS = 3'h5;
	localparam logic [2:0] ULSI_ADDR_INT_ID = 3'h2;
	// Line status bit positions
	localparam int ULSI_LS_RX_READY = 0;
	localparam int ULSI_LS_OVERRUN = 1;
	localparam int ULSI_LS_PARITY = 2;
	localparam int ULSI_LS_FRAMING = 3;
	localparam int ULSI_LS_BREAK = 4;
	localparam int ULSI_LS_THR_EMPTY = 5;
	localparam int ULSI_LS_TX_EMPTY = 6;
	localparam int ULSI_LS_FIFO_ERR = 7;
	// Line status value after master reset
	localparam logic [7:0] ULSI_LS_RESET = 8'h60;
	// Interrupt source codes, bits 3..1 of the id register
	localparam logic [2:0] ULSI_SRC_LINE = 3'h3;
	localparam logic [2:0] ULSI_SRC_RXDATA = 3'h2;
	localparam logic [2:0] ULSI_SRC_THR = 3'h1;
	localparam logic [2:0] ULSI_SRC_MODEM = 3'h0;
	// Timing figures at 50 MHz
	localparam int ULSI_CLK_NS = 20;
	localparam int ULSI_BIT_NS = 8680;
	localparam int ULSI_BIT_CYC = ULSI_BIT_NS / ULSI_CLK_NS;
	localparam int ULSI_HALF_BIT_CYC = (ULSI_BIT_CYC + 1) / 2;
	localparam int ULSI_FRAME_BITS = 11;
	localparam int ULSI_FRAME_CYC = ULSI_BIT_CYC * ULSI_FRAME_BITS;
	localparam int ULSI_THR_DELAY_CYC = ULSI_BIT_CYC * (ULSI_FRAME_BITS - 1);
	localparam int ULSI_FIFO_DEPTH = 4;
	localparam int ULSI_CNT_W = 16;
	localparam int ULSI_PTR_W = 2;
	localparam int ULSI_OCC_W = 3;

	// Received character with its per-character tags
	typedef struct packed {
		logic brk;
		logic frm;
		logic par;
		logic [7:0] data;
	} ulsi_rx_char_type;

	// Host register bus request
	typedef struct packed {
		logic cs;
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} ulsi_bus_type;

	// Enables and modes from neighbouring registers
	typedef struct packed {
		logic fifo_mode;
		logic en_line;
		logic en_rxdata;
		logic en_thr;
		logic en_modem;
		logic even_parity;
	} ulsi_ctrl_type;
endpackage : ulsi_pkg

// ===== design/ulsi_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Small receive buffer; tags travel with the data word
module ulsi_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic clear_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	import ulsi_pkg::*;
	localparam int PW = $clog2(DEPTH);
	// Storage and pointers, one extra bit for full/empty
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wp_r;
	logic [PW:0] rp_r;
	logic push;
	logic pop;

	assign in_ready_o = (wp_r - rp_r) != (PW+1)'(DEPTH);
	assign out_valid_o = wp_r != rp_r;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	// Head word is read combinationally from storage registers
	assign out_data_o = mem[rp_r[PW-1:0]];

	// Pointer and storage update, frozen while enable is low
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || (ce_i && clear_i)) begin
			wp_r <= '0;
			rp_r <= '0;
		end else if (ce_i) begin
			if (push) begin
				mem[wp_r[PW-1:0]] <= in_data_i;
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
		end
	end
endmodule : ulsi_fifo
`default_nettype wire

// ===== bench/ulsi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host processor model: one byte access at a time on the register bus
module ulsi_host_model (
	input wire logic ref_clk_i,
	output var ulsi_pkg::ulsi_bus_type bus_o,
	output var logic rvalid_o
);
	import ulsi_pkg::*;

	// Idle bus at time zero
	initial begin
		bus_o = '0;
		rvalid_o = 1'b0;
	end

	// Read data is due the cycle after the taking edge
	always @(posedge ref_clk_i) begin
		rvalid_o <= bus_o.cs & bus_o.rd;
	end

	// Drive after a falling edge, hold through the taking edge
	task automatic access(input logic rd, input logic [2:0] addr,
		input logic [7:0] wd);
		@(negedge ref_clk_i);
		bus_o <= '{1'b1, rd, ~rd, addr, wd};
		@(negedge ref_clk_i);
		// Released lines show the inverse so a stale copy never matches
		bus_o <= '{1'b0, 1'b0, 1'b0, ~addr, ~wd};
	endtask : access
endmodule : ulsi_host_model
`default_nettype wire

// ===== bench/ulsi_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ulsi_top_tb_top;
	import ulsi_pkg::*;

	// Clock, reset and the block's side inputs
	logic ref_clk_i, rst_n_i, ce_i, serial_input_pin_i;
	logic rx_done_i, rx_buf_read_i, tx_write_i, tx_fifo_empty_i;
	logic tx_fifo_two_i, tx_load_shift_i, tx_shift_busy_i, modem_pending_i;
	ulsi_bus_type bus;
	ulsi_ctrl_type ctrl;
	ulsi_rx_char_type rx_char, rx_head;
	logic [7:0] rdata, d0;
	logic rx_in_ready, rx_hold, irq, rvalid;
	// Notes of {mask, expected} for every read, oldest first
	logic [15:0] exp_q[$];
	logic [15:0] note;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h7a74e554;

	ulsi_top u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.bus_i(bus), .rdata_o(rdata), .ctrl_i(ctrl),
		.serial_input_pin_i(serial_input_pin_i), .rx_done_i(rx_done_i),
		.rx_char_i(rx_char), .rx_buf_read_i(rx_buf_read_i),
		.rx_in_ready_o(rx_in_ready), .rx_head_o(rx_head),
		.tx_write_i(tx_write_i), .tx_fifo_empty_i(tx_fifo_empty_i),
		.tx_fifo_two_i(tx_fifo_two_i), .tx_load_shift_i(tx_load_shift_i),
		.tx_shift_busy_i(tx_shift_busy_i), .modem_pending_i(modem_pending_i),
		.rx_hold_o(rx_hold), .irq_o(irq));

	ulsi_host_model u_host (.ref_clk_i(ref_clk_i), .bus_o(bus),
		.rvalid_o(rvalid));

	// 50 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	// Pseudo-random source for received data bytes
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction : lfsr_next

	// Compare and count; case inequality so unknowns never match
	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Note the expectation first, then let the host read
	task automatic rd(input logic [2:0] a, input logic [7:0] m,
		input logic [7:0] e);
		exp_q.push_back({m, e});
		u_host.access(1'b1, a, 8'h00);
	endtask : rd

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		u_host.access(1'b0, a, v);
	endtask : wr

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : wait_cyc

	// One finished character from the receiver, random payload
	task automatic push(input logic b, input logic f, input logic p);
		seed = lfsr_next(seed);
		@(negedge ref_clk_i);
		// Parity bit is right for the selected sense unless p asks not
		rx_char <= '{b, f, p ^ (ctrl.even_parity ? ^seed[7:0] :
			~^seed[7:0]), seed[7:0]};
		rx_done_i <= 1'b1;
		@(negedge ref_clk_i);
		rx_done_i <= 1'b0;
		rx_char <= '{~b, ~f, ~p, ~seed[7:0]};
	endtask : push

	// Host read of the receive buffer
	task automatic pop();
		@(negedge ref_clk_i);
		rx_buf_read_i <= 1'b1;
		@(negedge ref_clk_i);
		rx_buf_read_i <= 1'b0;
	endtask : pop

	// Transmit side strobe: host load or move into the shifter
	task automatic tx_pulse(input logic load);
		@(negedge ref_clk_i);
		if (load) begin
			tx_load_shift_i <= 1'b1;
		end else begin
			tx_write_i <= 1'b1;
		end
		@(negedge ref_clk_i);
		tx_load_shift_i <= 1'b0;
		tx_write_i <= 1'b0;
	endtask : tx_pulse

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	// Read monitor: rdata stands one cycle, checked mid-cycle
	always @(negedge ref_clk_i) begin
		if (rvalid === 1'b1) begin
			note = exp_q.pop_front();
			check("read data", note[7:0], rdata & note[15:8]);
		end
	end

	// Hang guard; the whole run needs about 5100 cycles
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			print_verdict();
		end
	end

	initial begin
		rst_n_i = 1'b0;
		ce_i = 1'b1;
		serial_input_pin_i = 1'b1;
		rx_done_i = 1'b0;
		rx_buf_read_i = 1'b0;
		tx_write_i = 1'b0;
		tx_fifo_empty_i = 1'b1;
		tx_fifo_two_i = 1'b0;
		tx_load_shift_i = 1'b0;
		tx_shift_busy_i = 1'b0;
		modem_pending_i = 1'b0;
		ctrl = '0;
		rx_char = '0;
		wait_cyc(10);
		rst_n_i <= 1'b1;
		// Reset values, nothing enabled
		rd(ULSI_ADDR_LINE_STATUS, 8'hff, 8'h60);
		rd(ULSI_ADDR_INT_ID, 8'hff, 8'h01);
		$display("test reset done");
		// All four sources pending, served in priority order
		ctrl <= 6'h1e;
		modem_pending_i <= 1'b1;
		push(1'b0, 1'b0, 1'b1);
		check("irq", 8'h01, {7'h0, irq});
		rd(ULSI_ADDR_INT_ID, 8'hff, 8'h06);
		rd(ULSI_ADDR_LINE_STATUS, 8'hff, 8'h65);
		rd(ULSI_ADDR_LINE_STATUS, 8'hff, 8'h61);
		rd(ULSI_ADDR_INT_ID, 8'hff, 8'h04);
		pop();
		rd(ULSI_ADDR_INT_ID, 8'hff, 8'h02);
		rd(ULSI_ADDR_INT_ID, 8'hff, 8'h00);
		modem_pending_i <= 1'b0;
		rd(ULSI_ADDR_INT_ID, 8'hff, 8'h01);
		check("irq idle", 8'h00, {7'h0, irq});
		ctrl <= '0;
		$display("test priority done");
		// Unread buffer overwritten by a badly framed character
		push(1'b0, 1'b0, 1'b0);
		push(1'b0, 1'b1, 1'b0);
		rd(ULSI_ADDR_LINE_STATUS, 8'hff, 8'h6b);
		pop();
		rd(ULSI_ADDR_LINE_STATUS, 8'hff, 8'h60);
		// Writes reach every bit except the FIFO error summary
		wr(ULSI_ADDR_LINE_STATUS, 8'hff);
		rd(ULSI_ADDR_LINE_STATUS, 8'hff, 8'h7f);
		wr(ULSI_ADDR_LINE_STATUS, 8'h60);
		rd(ULSI_ADDR_LINE_STATUS, 8'hff, 8'h60);
		$display("test errors done");
		// Transmit path in character mode
		tx_pulse(1'b0);
		rd(ULSI_ADDR_LINE_STATUS, 8'h60, 8'h00);
		tx_shift_busy_i <= 1'b1;
		tx_pulse(1'b1);
		rd(ULSI_ADDR_LINE_STATUS, 8'h60, 8'h20);
		tx_shift_busy_i <= 1'b0;
		wait_cyc(2);
		rd(ULSI_ADDR_LINE_STATUS, 8'h60, 8'h60);
		$display("test transmit done");
		// Line held low beyond a whole frame
		serial_input_pin_i <= 1'b0;
		wait_cyc(ULSI_FRAME_CYC + 20);
		serial_input_pin_i <= 1'b1;
		wait_cyc(2);
		check("hold after break", 8'h01, {7'h0, rx_hold});
		rd(ULSI_ADDR_LINE_STATUS, 8'h10, 8'h10);
		wait_cyc(ULSI_HALF_BIT_CYC + 4);
		check("hold released", 8'h00, {7'h0, rx_hold});
		pop();
		rd(ULSI_ADDR_LINE_STATUS, 8'h1e, 8'h00);
		$display("test break done");
		// FIFO mode: per-character tags, full buffer, overrun
		ctrl <= 6'h20;
		wait_cyc(2);
		rd(ULSI_ADDR_INT_ID, 8'hff, 8'hc1);
		wr(ULSI_ADDR_INT_ID, 8'h3e);
		rd(ULSI_ADDR_INT_ID, 8'hff, 8'hc1);
		push(1'b0, 1'b0, 1'b0);
		d0 = seed[7:0];
		push(1'b0, 1'b0, 1'b1);
		push(1'b0, 1'b0, 1'b0);
		push(1'b0, 1'b0, 1'b0);
		check("head data", d0, rx_head.data);
		check("fifo room", 8'h00, {7'h0, rx_in_ready});
		rd(ULSI_ADDR_LINE_STATUS, 8'h87, 8'h81);
		push(1'b0, 1'b0, 1'b0);
		rd(ULSI_ADDR_LINE_STATUS, 8'h02, 8'h02);
		check("head kept", d0, rx_head.data);
		pop();
		rd(ULSI_ADDR_LINE_STATUS, 8'h04, 8'h04);
		repeat (3) pop();
		rd(ULSI_ADDR_LINE_STATUS, 8'h01, 8'h00);
		rd(ULSI_ADDR_LINE_STATUS, 8'h80, 8'h00);
		$display("test fifo done");
		wait_cyc(4);
		print_verdict();
	end
endmodule : ulsi_top_tb_top
`default_nettype wire
